// ### prio_upper_pkg.sv
/*
 * constants for the upper interrupt priority register bank:
 * register offsets, implemented-bit masks, reset values and the
 * placement of every priority field.
 * assumes a 32-bit bus with one aligned word per register.
 */
package prio_upper_pkg;

    // bank geometry
    localparam int NUM_REGS = 9;
    localparam int NUM_SRC = 19;
    localparam int REG_W = 16;
    localparam int FIELD_W = 3;
    localparam int IDX_W = 4;
    localparam int IDX_LSB = 2;
    localparam int DATA_W = 32;

    // byte offsets of the nine registers
    localparam logic [31:0] OFF_COMPARE5_7_CAPTURE6 = 32'h0000_0000;
    localparam logic [31:0] OFF_PARPORT_COMPARE8 = 32'h0000_0004;
    localparam logic [31:0] OFF_I2C_SECOND = 32'h0000_0008;
    localparam logic [31:0] OFF_EXT_IRQ3_4 = 32'h0000_000C;
    localparam logic [31:0] OFF_CALENDAR_CLOCK = 32'h0000_0010;
    localparam logic [31:0] OFF_CRC_UART_ERRORS = 32'h0000_0014;
    localparam logic [31:0] OFF_LOW_VOLTAGE = 32'h0000_0018;
    localparam logic [31:0] OFF_CAP_MEASURE = 32'h0000_001C;
    localparam logic [31:0] OFF_UART_THIRD = 32'h0000_0020;

    // register indices
    localparam int R_CMP = 0;
    localparam int R_PAR = 1;
    localparam int R_I2C = 2;
    localparam int R_EXT = 3;
    localparam int R_CAL = 4;
    localparam int R_CRC = 5;
    localparam int R_LVD = 6;
    localparam int R_CAP = 7;
    localparam int R_U3 = 8;

    // field lsb positions
    localparam int F_HI = 12;
    localparam int F_MID = 8;
    localparam int F_LO = 4;
    localparam int F_BOT = 0;

    // priority codes
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_MIN = 3'h1;
    localparam logic [2:0] PRIO_MAX = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h4;

    // implemented bits per register, index order
    localparam logic [15:0] REG_MASK [NUM_REGS] = '{
        16'h7777, 16'h0077, 16'h0770, 16'h0770, 16'h0700,
        16'h7770, 16'h0007, 16'h0070, 16'h7770};

    // reset value: msb of each field set
    localparam logic [15:0] REG_RESET [NUM_REGS] = '{
        16'h4444, 16'h0044, 16'h0440, 16'h0440, 16'h0400,
        16'h4440, 16'h0004, 16'h0040, 16'h4440};

    // sources: holding register and field lsb
    localparam int SRC_REG [NUM_SRC] = '{
        R_CMP, R_CMP, R_CMP, R_CMP, R_PAR, R_PAR, R_I2C, R_I2C,
        R_EXT, R_EXT, R_CAL, R_CRC, R_CRC, R_CRC, R_LVD, R_CAP,
        R_U3, R_U3, R_U3};
    localparam int SRC_LSB [NUM_SRC] = '{
        F_HI, F_MID, F_LO, F_BOT, F_LO, F_BOT, F_MID, F_LO,
        F_MID, F_LO, F_MID, F_HI, F_MID, F_LO, F_BOT, F_LO,
        F_HI, F_MID, F_LO};

    // ahb codes
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### prio_upper_regs.sv
/*
 * upper interrupt priority register bank with an ahb-lite slave.
 * nine 16-bit registers of 3-bit priority fields, presented to the
 * arbitration logic as registered outputs with an enable per source.
 * assumes a single ahb-lite master on ref_clk_i, word transfers only.
 */
`timescale 1ns/10ps
`default_nettype none

module prio_upper_regs
    import prio_upper_pkg::*;
(
    input wire logic ref_clk_i, // system clock
    input wire logic rst_n_i, // sync reset, low
    input wire logic ce_i, // clock enable
    input wire logic hsel_i, // slave select
    input wire logic [31:0] haddr_i, // byte address
    input wire logic [1:0] htrans_i, // transfer type
    input wire logic hwrite_i, // write when high
    input wire logic [2:0] hsize_i, // transfer size
    input wire logic [31:0] hwdata_i, // write data
    input wire logic hready_i, // bus ready
    output logic hreadyout_o, // slave ready
    output logic hresp_o, // always okay
    output logic [31:0] hrdata_o, // read data
    output logic [2:0] compare7_priority_o, // compare 7 level
    output logic [2:0] compare6_priority_o, // compare 6 level
    output logic [2:0] compare5_priority_o, // compare 5 level
    output logic [2:0] capture6_priority_o, // capture 6 level
    output logic [2:0] parallel_port_priority_o, // parallel port
    output logic [2:0] compare8_priority_o, // compare 8 level
    output logic [2:0] i2c_second_master_priority_o, // i2c2 master
    output logic [2:0] i2c_second_slave_priority_o, // i2c2 slave
    output logic [2:0] ext_irq4_priority_o, // ext irq 4
    output logic [2:0] ext_irq3_priority_o, // ext irq 3
    output logic [2:0] calendar_alarm_priority_o, // calendar
    output logic [2:0] checksum_error_priority_o, // crc error
    output logic [2:0] uart_second_error_priority_o, // uart2 error
    output logic [2:0] uart_first_error_priority_o, // uart1 error
    output logic [2:0] low_voltage_priority_o, // low voltage
    output logic [2:0] cap_measure_priority_o, // cap measure
    output logic [2:0] uart_third_tx_priority_o, // uart3 tx
    output logic [2:0] uart_third_rx_priority_o, // uart3 rx
    output logic [2:0] uart_third_error_priority_o, // uart3 error
    output logic [18:0] source_enable_o // per source, high if level nonzero
);

    // register storage, one word per index
    logic [15:0] store [NUM_REGS];
    logic [15:0] next_store [NUM_REGS];
    logic [15:0] view [NUM_REGS];

    // pending write data phase
    logic wr_pend;
    logic [IDX_W-1:0] wr_idx;

    // address phase decode
    wire addr_phase = hsel_i && hready_i && htrans_i[1];
    wire [IDX_W-1:0] addr_idx = haddr_i[IDX_LSB +: IDX_W];
    wire addr_aligned = (haddr_i[IDX_LSB-1:0] == '0);
    wire addr_upper_zero = (haddr_i[31:IDX_LSB+IDX_W] == '0);
    wire addr_in_bank = ({1'b0, addr_idx} < 5'(NUM_REGS));
    wire addr_hit = addr_aligned && addr_upper_zero && addr_in_bank;
    wire size_word = (hsize_i == HSIZE_WORD);
    wire wr_take = addr_phase && hwrite_i && addr_hit && size_word;
    wire rd_take = addr_phase && !hwrite_i;

    // next register values; only a pending write changes a word
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            wire hit_here = wr_pend && (wr_idx == IDX_W'(g));
            assign next_store[g] = hit_here ?
                (hwdata_i[REG_W-1:0] & REG_MASK[g]) : store[g];
            // writes merge into reads so a read right behind sees it
            assign view[g] = next_store[g];
        end
    endgenerate

    // read mux; unmapped words read zero
    wire [15:0] rd_word = addr_hit ? view[addr_idx] : 16'h0000;
    wire [31:0] rd_data = {16'h0000, rd_word};

    // register bank
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_store
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    store[g] <= REG_RESET[g];
                end else if (ce_i) begin
                    store[g] <= next_store[g];
                end
            end
        end
    endgenerate

    // write address capture for the data phase
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_pend <= 1'b0;
            wr_idx <= '0;
        end else if (ce_i) begin
            wr_pend <= wr_take;
            wr_idx <= addr_idx;
        end
    end

    // bus answer: zero wait states, okay always, data from a flop
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= HRESP_OKAY;
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= HRESP_OKAY;
            hrdata_o <= rd_take ? rd_data : 32'h0000_0000;
        end
    end

    // per-source enable; disabled code keeps the source silent
    logic [NUM_SRC-1:0] next_enable;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            wire [2:0] lvl = next_store[SRC_REG[g]][SRC_LSB[g] +: FIELD_W];
            assign next_enable[g] = (lvl != PRIO_OFF);
        end
    endgenerate

    // enable tracks the field in the same cycle as the level outputs
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            source_enable_o <= '1;
        end else if (ce_i) begin
            source_enable_o <= next_enable;
        end
    end

    // field outputs are slices of the stored words
    // stored level out
    assign compare7_priority_o = store[R_CMP][F_HI +: FIELD_W];
    assign compare6_priority_o = store[R_CMP][F_MID +: FIELD_W];
    assign compare5_priority_o = store[R_CMP][F_LO +: FIELD_W];
    assign capture6_priority_o = store[R_CMP][F_BOT +: FIELD_W];
    assign parallel_port_priority_o = store[R_PAR][F_LO +: FIELD_W];
    assign compare8_priority_o = store[R_PAR][F_BOT +: FIELD_W];
    assign i2c_second_master_priority_o = store[R_I2C][F_MID +: FIELD_W];
    assign i2c_second_slave_priority_o = store[R_I2C][F_LO +: FIELD_W];
    assign ext_irq4_priority_o = store[R_EXT][F_MID +: FIELD_W];
    assign ext_irq3_priority_o = store[R_EXT][F_LO +: FIELD_W];
    assign calendar_alarm_priority_o = store[R_CAL][F_MID +: FIELD_W];
    assign checksum_error_priority_o = store[R_CRC][F_HI +: FIELD_W];
    assign uart_second_error_priority_o = store[R_CRC][F_MID +: FIELD_W];
    assign uart_first_error_priority_o = store[R_CRC][F_LO +: FIELD_W];
    assign low_voltage_priority_o = store[R_LVD][F_BOT +: FIELD_W];
    assign cap_measure_priority_o = store[R_CAP][F_LO +: FIELD_W];
    assign uart_third_tx_priority_o = store[R_U3][F_HI +: FIELD_W];
    assign uart_third_rx_priority_o = store[R_U3][F_MID +: FIELD_W];
    assign uart_third_error_priority_o = store[R_U3][F_LO +: FIELD_W];

endmodule

`default_nettype wire

// ### prio_upper_monitor.sv
/* checker for the upper priority bank: read path, field timing, enables.
   assumes one ahb-lite master with hready_i tied to hreadyout_o. */
`timescale 1ns/10ps
`default_nettype none
module prio_upper_monitor (
    input wire logic ref_clk_i, // clock
    input wire logic rst_n_i, // sync reset, low
    input wire logic ce_i, // clock enable
    input wire logic hsel_i, // select
    input wire logic [31:0] haddr_i, // address
    input wire logic [1:0] htrans_i, // transfer type
    input wire logic hwrite_i, // write
    input wire logic [2:0] hsize_i, // size
    input wire logic [31:0] hwdata_i, // write data
    input wire logic hready_i, // bus ready
    input wire logic [31:0] hrdata_o, // read data
    input wire logic [2:0] compare7_priority_o, // compare 7
    input wire logic [2:0] capture6_priority_o, // capture 6
    input wire logic [2:0] low_voltage_priority_o, // low voltage
    input wire logic [18:0] source_enable_o // enables
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // accepted address phases, by direction
    wire take = ce_i & hsel_i & hready_i & htrans_i[1];
    wire rd_take = take & ~hwrite_i;
    wire wr_take = take & hwrite_i;
    wire [2:0] wd_lo = hwdata_i[2:0];
    upper_zero_a: assert property (hrdata_o[31:16] == 16'h0000) else $error("upper read bits set");
    cmp_enable_a: assert property (source_enable_o[0] == (compare7_priority_o != 3'h0))
        else $error("compare 7 enable wrong");
    lvd_enable_a: assert property (source_enable_o[14] == (low_voltage_priority_o != 3'h0))
        else $error("low voltage enable wrong");
    reset_load_a: assert property (disable iff (1'b0) !rst_n_i |=> compare7_priority_o == 3'h4 &&
        source_enable_o == 19'h7_FFFF) else $error("reset level not four");
    idle_rdata_a: assert property (ce_i && !rd_take |=> hrdata_o == 32'h0000_0000)
        else $error("read data not cleared");
    read_lvd_a: assert property (rd_take && haddr_i == 32'h0000_0018 |=>
        hrdata_o == {29'h0000_0000, low_voltage_priority_o}) else $error("low voltage word wrong");
    read_cmp_a: assert property (rd_take && haddr_i == 32'h0000_0000 |=>
        hrdata_o[15:12] == {1'b0, compare7_priority_o} && hrdata_o[3:0] == {1'b0, capture6_priority_o})
        else $error("compare word wrong");
    hold_field_a: assert property (!wr_take |=> ##1 $stable(compare7_priority_o))
        else $error("field moved without write");
    write_lvd_a: assert property (wr_take && haddr_i == 32'h0000_0018 && hsize_i == 3'h2 ##1 ce_i
        |=> low_voltage_priority_o == $past(wd_lo)) else $error("low voltage not stored");
    // enable low must freeze read data and enables alike
    ce_freeze_a: assert property (!ce_i |=> $stable(source_enable_o) && $stable(hrdata_o))
        else $error("state moved with enable low");
endmodule
bind prio_upper_regs prio_upper_monitor u_prio_upper_monitor (.ref_clk_i, .rst_n_i, .ce_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .compare7_priority_o,
    .capture6_priority_o, .low_voltage_priority_o, .source_enable_o);
`default_nettype wire

// ### tb.sv
/* self-checking bench for the upper priority bank with a word model.
   assumes the design answers with zero wait states on ahb-lite. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
    import prio_upper_pkg::*;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [31:0] haddr_i = '0, hwdata_i = '0, rd;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    wire logic hreadyout_o, hresp_o;
    wire logic [31:0] hrdata_o;
    wire logic [18:0] source_enable_o;
    wire logic [2:0] fo [19];
    int err_total = 0, n_tests = 0, seed = 32'h4735, i, j, k;
    logic [15:0] mdl [10];
    prio_upper_regs u_prio_upper_regs (.ref_clk_i, .rst_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
        .compare7_priority_o(fo[0]), .compare6_priority_o(fo[1]), .compare5_priority_o(fo[2]),
        .capture6_priority_o(fo[3]), .parallel_port_priority_o(fo[4]), .compare8_priority_o(fo[5]),
        .i2c_second_master_priority_o(fo[6]), .i2c_second_slave_priority_o(fo[7]),
        .ext_irq4_priority_o(fo[8]), .ext_irq3_priority_o(fo[9]), .calendar_alarm_priority_o(fo[10]),
        .checksum_error_priority_o(fo[11]), .uart_second_error_priority_o(fo[12]),
        .uart_first_error_priority_o(fo[13]), .low_voltage_priority_o(fo[14]),
        .cap_measure_priority_o(fo[15]), .uart_third_tx_priority_o(fo[16]),
        .uart_third_rx_priority_o(fo[17]), .uart_third_error_priority_o(fo[18]), .source_enable_o);
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // one single transfer; waits on hready in both phases
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] dat);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= dat;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic mreset();
        for (k = 0; k < 10; k++)
            mdl[k] = (k < NUM_REGS) ? (REG_MASK[k] & 16'h4444) : 16'h0000;
    endtask
    task automatic wr(input int r, input logic [31:0] dat);
        xfer(32'(r * 4), 1'b1, dat);
        if (hsize_i == 3'h2 && r < NUM_REGS)
            mdl[r] = dat[15:0] & REG_MASK[r];
    endtask
    // read back one word, then every field and enable
    task automatic chk(input int r);
        logic [18:0] en;
        xfer(32'(r * 4), 1'b0, '0);
        `CHK(rd, {16'h0000, mdl[r]})
        `CHK(hresp_o, HRESP_OKAY)
        for (k = 0; k < NUM_SRC; k++) begin
            en[k] = mdl[SRC_REG[k]][SRC_LSB[k] +: 3] != 3'h0;
            `CHK(fo[k], mdl[SRC_REG[k]][SRC_LSB[k] +: 3])
        end
        `CHK(source_enable_o, en)
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog well past the expected run
    initial begin
        #100us;
        err_total++;
        report_and_stop();
    end
    initial begin
        mreset();
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 10; i++)
            chk(i);
        for (i = 0; i < 8; i++) begin
            wr(6, {29'h1FFF_FFFF, 3'(i)});
            chk(6);
        end
        // unaligned and far writes dropped, an unaligned read gives zero
        xfer(32'h0000_0019, 1'b1, 32'h0000_0000);
        xfer(32'h0001_0018, 1'b1, 32'h0000_0000);
        chk(6);
        xfer(32'h0000_001A, 1'b0, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        // random words, sizes and enable gaps
        for (i = 0; i < 80; i++) begin
            j = {$random(seed)} % 10;
            hsize_i <= (($random(seed) & 3) == 0) ? 3'h0 : 3'h2;
            wr(j, $random(seed));
            ce_i <= 1'($random(seed));
            @(posedge ref_clk_i);
            ce_i <= 1'b1;
            chk(j);
        end
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        mreset();
        chk(0);
        chk(8);
        report_and_stop();
    end
endmodule
`default_nettype wire
